// File: mmtt_top.sv
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// Function
// [RL1] Four page sizes: 8K, 64K, 512K, 4M
// [RL2] Separate data and instruction lookups each cycle
// [RL3] 64-bit VA in, 43-bit PA out
// [RL4] Data side: two 512-entry two-way buffers
// [RL5] Data side: 16-entry associative buffer, mixed pages
// [RL6] Instruction side: 128 two-way 8K, 16 associative
// [RL7] No match raises miss, no table walk
// [RL8] Multiple matches undefined but contention free
// [RL9] Entry is tag word plus data word
// [RL10] Global flag ignores context on compare
// [RL11] Tag holds context and VA 63:22
// [RL12] Entry counts only when valid bit set
// [RL13] Size code in data bits 62:61
// [RL14] No-fault-only pages fault other accesses
// [RL15] Invert endianness flag swaps byte order
// [RL16] Software fields and reserved read zero
// [RL17] Page number kept, low bits ignored translating
// [RL18] Locked valid entries skipped by replacement
// [RL19] Software keeps one entry unlocked, max 15
// [RL20] Lock exists only in associative buffers
// [RL21] Cacheable codes 00, 01 mean non-cacheable
// [RL22] Code 11 allows first-level cache placement
// [RL23] Privileged page faults outside supervisor
// [RL24] Store to read-only page raises protection
// [RL25] Side-effect page traps no-fault loads, orders
// [RL26] Compare tag only above page offset
// [RL27] Readback returns stored fields as written
module mmtt_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic d_req_valid,
  input wire logic [63:0] d_va,
  input wire logic [12:0] d_ctx,
  input wire logic d_write,
  input wire logic d_nofault,
  input wire logic d_priv,
  input wire logic d_little,
  output logic d_resp_valid,
  output logic [42:0] d_pa,
  output logic d_miss,
  output logic d_exc,
  output logic [7:0] d_fault_type,
  output logic d_prot,
  output logic d_little_out,
  output logic d_cacheable,
  output logic d_l1_cacheable,
  output logic d_side_effect,
  input wire logic i_req_valid,
  input wire logic [63:0] i_va,
  input wire logic [12:0] i_ctx,
  input wire logic i_priv,
  output logic i_resp_valid,
  output logic [42:0] i_pa,
  output logic i_miss,
  output logic i_exc,
  output logic i_cacheable
);
  import mmtt_pkg::*;

  // Compare mask for page number bits 21:13 by size
  function automatic logic [8:0] low_mask(input logic [1:0] sz);
    unique case (sz)
      SZ_8K: low_mask = LM_8K;
      SZ_64K: low_mask = LM_64K;
      SZ_512K: low_mask = LM_512K;
      SZ_4M: low_mask = LM_4M; // RL1 RL13
    endcase
  endfunction

  // Hit test of one entry
  function automatic logic hit_chk(input logic [63:0] tg,
    input logic [8:0] lo, input logic [63:0] dt, input logic vl,
    input logic [63:0] va, input logic [12:0] cx);
    hit_chk = vl && dt[D_V] // RL12
      && (tg[41:0] == va[63:22]) // RL11
      && (((lo ^ va[21:13]) & low_mask(dt[D_SZ_LSB +: 2])) == 9'h000) // RL26
      && (tg[TAG_G] || (tg[TAG_CTX_LSB +: 13] == cx)); // RL10
  endfunction

  // Set index above the page offset
  function automatic logic [7:0] set_idx(input logic [50:0] vpn,
    input logic [1:0] sz, input logic isi);
    logic [50:0] sh;
    sh = vpn >> ({2'b00, sz} * 4'd3);
    set_idx = isi ? {2'b00, sh[5:0]} : sh[7:0]; // RL4 RL6
  endfunction

  // Page number replaces VPN, offset passes through
  function automatic logic [42:0] make_pa(input logic [63:0] dt,
    input logic [63:0] va);
    logic [8:0] m;
    m = low_mask(dt[D_SZ_LSB +: 2]);
    make_pa = {dt[42:22], (dt[21:13] & m) | (va[21:13] & ~m), va[12:0]}; // RL3 RL17
  endfunction

  // Byte lane merge for bus writes
  function automatic logic [31:0] be_merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    be_merge = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        be_merge[b*8 +: 8] = wd[b*8 +: 8];
  endfunction

  // Stored bits of a data word per side and buffer kind
  function automatic logic [63:0] dmask(input logic sd, input logic fa);
    dmask = sd ? (fa ? DMASK_I_FA : DMASK_I_SA)
      : (fa ? DMASK_D_FA : DMASK_D_SA); // RL14 RL15 RL16 RL20 RL24
  endfunction

  // Entry storage: side or unit, way, index
  logic [63:0] fa_tag [2][FA_N];
  logic [63:0] fa_dat [2][FA_N];
  logic [8:0] fa_low [2][FA_N];
  logic [63:0] sa_tag [N_SA][2][SA_SETS];
  logic [63:0] sa_dat [N_SA][2][SA_SETS];
  logic [8:0] sa_low [N_SA][2][SA_SETS];
  logic [FA_N-1:0] fa_vld_reg [2];
  logic [FA_N-1:0] fa_vld_next [2];
  logic [SA_SETS-1:0] sa_vld_reg [N_SA][2];
  logic [SA_SETS-1:0] sa_vld_next [N_SA][2];

  logic [3:0] cfg_reg, cfg_next;
  logic [63:0] tag_in_reg, tag_in_next;
  logic [63:0] dat_in_reg, dat_in_next;
  logic [8:0] vlow_in_reg, vlow_in_next;
  logic [15:0] cmd_reg, cmd_next;
  logic go_reg, go_next;
  logic [63:0] rtag_reg, rtag_next;
  logic [63:0] rdat_reg, rdat_next;
  logic [8:0] rlow_reg, rlow_next;
  logic [13:0] stat_reg, stat_next;
  logic rr_reg, rr_next;
  logic [3:0] fptr_reg, fptr_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic acc;

  // Lookup inputs per side
  logic [63:0] lva [2];
  logic [12:0] lctx [2];
  logic [1:0] usz [N_SA];
  wire [7:0] uidx [N_SA];
  wire [FA_N-1:0] fa_hit [2];
  wire [1:0] sa_hit [N_SA];
  wire [63:0] fa_hd [2][FA_N];
  wire [63:0] sa_hd [N_SA][2];
  logic [63:0] hd [2];
  logic hit [2];

  assign lva[0] = d_va;
  assign lva[1] = i_va;
  assign lctx[0] = d_ctx;
  assign lctx[1] = i_ctx;
  assign usz[0] = cfg_reg[CFG_SZ0_LSB +: 2];
  assign usz[1] = cfg_reg[CFG_SZ1_LSB +: 2];
  assign usz[2] = SZ_8K;

  // Associative buffer compare per entry, both sides at once
  for (genvar s = 0; s < 2; s++)
  begin : g_fa
    for (genvar e = 0; e < FA_N; e++)
    begin : g_ent
      assign fa_hit[s][e] = hit_chk(fa_tag[s][e], fa_low[s][e],
        fa_dat[s][e], fa_vld_reg[s][e], lva[s], lctx[s]); // RL2 RL5 RL6
      assign fa_hd[s][e] = fa_hit[s][e] ? fa_dat[s][e] : 64'h0;
    end
  end

  // Set-associative compare per unit and way
  for (genvar u = 0; u < N_SA; u++)
  begin : g_sa
    localparam int SD = (u == I_UNIT) ? 1 : 0;
    assign uidx[u] = set_idx(lva[SD][63:13], usz[u], SD == 1);
    for (genvar w = 0; w < 2; w++)
    begin : g_way
      assign sa_hit[u][w] = hit_chk(sa_tag[u][w][uidx[u]],
        sa_low[u][w][uidx[u]], sa_dat[u][w][uidx[u]],
        sa_vld_reg[u][w][uidx[u]], lva[SD], lctx[SD]); // RL4 RL6
      assign sa_hd[u][w] = sa_hit[u][w] ? sa_dat[u][w][uidx[u]] : 64'h0;
    end
  end

  // Matches are ORed, so several hits only blend values
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      hd[s] = 64'h0;
      hit[s] = |fa_hit[s];
      for (int e = 0; e < FA_N; e++)
        hd[s] = hd[s] | fa_hd[s][e]; // RL8
    end
    for (int u = 0; u < N_SA; u++)
      for (int w = 0; w < 2; w++)
      begin
        hd[(u == I_UNIT) ? 1 : 0] = hd[(u == I_UNIT) ? 1 : 0] | sa_hd[u][w]; // RL8
        hit[(u == I_UNIT) ? 1 : 0] = hit[(u == I_UNIT) ? 1 : 0] | sa_hit[u][w];
      end
  end

  // Translation answers and access checks
  logic d_rv_n, d_miss_n, d_exc_n, d_prot_n, d_le_n, d_c_n, d_l1_n, d_se_n;
  logic i_rv_n, i_miss_n, i_exc_n, i_c_n;
  logic [7:0] d_ft_n;
  logic [42:0] d_pa_n, i_pa_n;
  always_comb
  begin
    d_rv_n = d_req_valid; // RL2
    d_pa_n = make_pa(hd[0], d_va); // RL3
    d_miss_n = d_req_valid && !hit[0]; // RL7
    d_exc_n = 1'b0;
    d_ft_n = FT_NONE;
    if (d_req_valid && hit[0])
    begin
      if (hd[0][D_P] && !d_priv)
      begin
        d_exc_n = 1'b1; // RL23
        d_ft_n = FT_PRIV;
      end
      else if (hd[0][D_NFO] && !d_nofault)
      begin
        d_exc_n = 1'b1; // RL14
        d_ft_n = FT_NFO;
      end
      else if (hd[0][D_E] && d_nofault)
      begin
        d_exc_n = 1'b1; // RL25
        d_ft_n = FT_SIDE_NF;
      end
    end
    d_prot_n = d_req_valid && hit[0] && !d_exc_n && d_write && !hd[0][D_W]; // RL24
    d_le_n = d_little ^ hd[0][D_IE]; // RL15
    d_c_n = hd[0][D_CP]; // RL21
    d_l1_n = hd[0][D_CP] && hd[0][D_CV]; // RL22
    d_se_n = hd[0][D_E]; // RL25
    i_rv_n = i_req_valid; // RL2
    i_pa_n = make_pa(hd[1], i_va); // RL3
    i_miss_n = i_req_valid && !hit[1]; // RL7
    i_exc_n = i_req_valid && hit[1] && hd[1][D_P] && !i_priv; // RL23
    i_c_n = hd[1][D_CP]; // RL21 RL22
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      d_resp_valid <= 1'b0;
      d_pa <= 43'h0;
      d_miss <= 1'b0;
      d_exc <= 1'b0;
      d_fault_type <= FT_NONE;
      d_prot <= 1'b0;
      d_little_out <= 1'b0;
      d_cacheable <= 1'b0;
      d_l1_cacheable <= 1'b0;
      d_side_effect <= 1'b0;
      i_resp_valid <= 1'b0;
      i_pa <= 43'h0;
      i_miss <= 1'b0;
      i_exc <= 1'b0;
      i_cacheable <= 1'b0;
    end
    else
    begin
      d_resp_valid <= d_rv_n;
      d_pa <= d_pa_n;
      d_miss <= d_miss_n;
      d_exc <= d_exc_n;
      d_fault_type <= d_ft_n;
      d_prot <= d_prot_n;
      d_little_out <= d_le_n;
      d_cacheable <= d_c_n;
      d_l1_cacheable <= d_l1_n;
      d_side_effect <= d_se_n;
      i_resp_valid <= i_rv_n;
      i_pa <= i_pa_n;
      i_miss <= i_miss_n;
      i_exc <= i_exc_n;
      i_cacheable <= i_c_n;
    end
  end

  // Command location: explicit or chosen by replacement
  logic [1:0] op, c_unit;
  logic c_side, loc_fa, loc_way, flock, mem_we;
  logic [1:0] fsz, loc_u;
  logic [7:0] loc_idx, fidx;
  logic [3:0] loc_fe, f_free, f_unl;
  logic has_free, has_unl;
  logic [63:0] wdat;
  assign op = cmd_reg[1:0];
  assign c_side = cmd_reg[CMD_SIDE];
  assign c_unit = cmd_reg[CMD_UNIT_LSB +: 2];
  assign fsz = dat_in_reg[D_SZ_LSB +: 2];
  assign flock = dat_in_reg[D_L] && (fsz != SZ_8K); // RL20
  assign fidx = set_idx({tag_in_reg[41:0], vlow_in_reg}, fsz, c_side);
  always_comb
  begin
    f_free = 4'h0;
    f_unl = 4'h0;
    has_free = 1'b0;
    has_unl = 1'b0;
    for (int e = FA_N - 1; e >= 0; e--)
    begin
      if (!fa_vld_reg[c_side][e])
      begin
        f_free = 4'(e);
        has_free = 1'b1;
      end
      if (fa_vld_reg[c_side][e] && !fa_dat[c_side][e][D_L])
      begin
        f_unl = 4'(e); // RL18
        has_unl = 1'b1;
      end
    end
    loc_fa = (c_unit == 2'h0);
    loc_u = c_side ? 2'(I_UNIT) : 2'(c_unit[1]);
    loc_way = cmd_reg[CMD_WAY];
    loc_idx = c_side ? {2'b00, cmd_reg[CMD_IDX_LSB +: 6]}
      : cmd_reg[CMD_IDX_LSB +: 8];
    loc_fe = cmd_reg[CMD_IDX_LSB +: 4];
    if (op == OP_FILL)
    begin
      loc_idx = fidx;
      loc_fa = 1'b1;
      if (!c_side && !flock && fsz == usz[0])
      begin
        loc_fa = 1'b0; // RL4
        loc_u = 2'h0;
      end
      else if (!c_side && !flock && fsz == usz[1])
      begin
        loc_fa = 1'b0; // RL4
        loc_u = 2'h1;
      end
      else if (c_side && !flock && fsz == SZ_8K)
      begin
        loc_fa = 1'b0; // RL6
        loc_u = 2'(I_UNIT);
      end
      if (!sa_vld_reg[loc_u][0][loc_idx])
        loc_way = 1'b0;
      else if (!sa_vld_reg[loc_u][1][loc_idx])
        loc_way = 1'b1;
      else
        loc_way = rr_reg;
      // Free slot first, then unlocked, else rotate over locked
      loc_fe = has_free ? f_free : (has_unl ? f_unl : fptr_reg); // RL18 RL19
    end
    mem_we = go_reg && (op == OP_FILL || op == OP_WRITE);
    wdat = dat_in_reg & dmask(c_side, loc_fa); // RL16 RL20
    if (fsz == SZ_8K)
      wdat[D_L] = 1'b0; // RL20
  end

  // Entry arrays, written only by fill or indexed write
  always_ff @(posedge clk)
  begin
    if (mem_we && loc_fa)
    begin
      fa_tag[c_side][loc_fe] <= tag_in_reg & TAG_MASK; // RL9 RL11
      fa_dat[c_side][loc_fe] <= wdat; // RL9
      fa_low[c_side][loc_fe] <= vlow_in_reg;
    end
    if (mem_we && !loc_fa)
    begin
      sa_tag[loc_u][loc_way][loc_idx] <= tag_in_reg & TAG_MASK; // RL9 RL11
      sa_dat[loc_u][loc_way][loc_idx] <= wdat; // RL9
      sa_low[loc_u][loc_way][loc_idx] <= vlow_in_reg;
    end
  end

  // Valid bits, replacement pointers, readback and status
  always_comb
  begin
    fa_vld_next = fa_vld_reg;
    sa_vld_next = sa_vld_reg;
    rr_next = rr_reg;
    fptr_next = fptr_reg;
    rtag_next = rtag_reg;
    rdat_next = rdat_reg;
    rlow_next = rlow_reg;
    stat_next = stat_reg;
    if (mem_we && loc_fa)
      fa_vld_next[c_side][loc_fe] = wdat[D_V]; // RL12
    if (mem_we && !loc_fa)
      sa_vld_next[loc_u][loc_way][loc_idx] = wdat[D_V]; // RL12
    if (go_reg && op == OP_FILL)
    begin
      rr_next = !rr_reg;
      if (loc_fa && !has_free && !has_unl)
        fptr_next = fptr_reg + 4'h1; // RL18
    end
    if (go_reg && op == OP_READ && loc_fa)
    begin
      rtag_next = fa_tag[c_side][loc_fe]; // RL27
      rdat_next = fa_dat[c_side][loc_fe];
      rdat_next[D_V] = rdat_next[D_V] && fa_vld_reg[c_side][loc_fe];
      rlow_next = fa_low[c_side][loc_fe];
    end
    if (go_reg && op == OP_READ && !loc_fa)
    begin
      rtag_next = sa_tag[loc_u][loc_way][loc_idx]; // RL27
      rdat_next = sa_dat[loc_u][loc_way][loc_idx];
      rdat_next[D_V] = rdat_next[D_V] && sa_vld_reg[loc_u][loc_way][loc_idx];
      rlow_next = sa_low[loc_u][loc_way][loc_idx];
    end
    if (go_reg)
      stat_next = {1'b1, loc_fa, c_side, loc_u, loc_way,
        loc_fa ? {4'h0, loc_fe} : loc_idx};
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int s = 0; s < 2; s++)
        fa_vld_reg[s] <= '0;
      for (int u = 0; u < N_SA; u++)
        for (int w = 0; w < 2; w++)
          sa_vld_reg[u][w] <= '0;
      rr_reg <= 1'b0;
      fptr_reg <= 4'h0;
      rtag_reg <= 64'h0;
      rdat_reg <= 64'h0;
      rlow_reg <= 9'h000;
      stat_reg <= 14'h0000;
    end
    else
    begin
      fa_vld_reg <= fa_vld_next;
      sa_vld_reg <= sa_vld_next;
      rr_reg <= rr_next;
      fptr_reg <= fptr_next;
      rtag_reg <= rtag_next;
      rdat_reg <= rdat_next;
      rlow_reg <= rlow_next;
      stat_reg <= stat_next;
    end
  end

  // Avalon slave: one wait cycle, then answer
  assign acc = avs_write && !wait_reg;
  always_comb
  begin
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    cfg_next = cfg_reg;
    tag_in_next = tag_in_reg;
    dat_in_next = dat_in_reg;
    vlow_in_next = vlow_in_reg;
    cmd_next = cmd_reg;
    go_next = 1'b0;
    if ((avs_read || avs_write) && wait_reg)
    begin
      wait_next = 1'b0;
      unique case (avs_address)
        REG_CONFIG: rdata_next = {28'h0, cfg_reg};
        REG_TAG_LO: rdata_next = tag_in_reg[31:0];
        REG_TAG_HI: rdata_next = tag_in_reg[63:32];
        REG_DATA_LO: rdata_next = dat_in_reg[31:0];
        REG_DATA_HI: rdata_next = dat_in_reg[63:32];
        REG_VA_LOW: rdata_next = {23'h0, vlow_in_reg};
        REG_CMD: rdata_next = {16'h0, cmd_reg};
        REG_RTAG_LO: rdata_next = rtag_reg[31:0];
        REG_RTAG_HI: rdata_next = rtag_reg[63:32];
        REG_RDATA_LO: rdata_next = rdat_reg[31:0];
        REG_RDATA_HI: rdata_next = rdat_reg[63:32];
        REG_RVA_LOW: rdata_next = {23'h0, rlow_reg};
        REG_STATUS: rdata_next = {18'h0, stat_reg};
        default: rdata_next = 32'h0;
      endcase
    end
    if (acc)
    begin
      unique case (avs_address)
        REG_CONFIG: cfg_next = 4'(be_merge({28'h0, cfg_reg}, avs_writedata,
          avs_byteenable));
        REG_TAG_LO: tag_in_next[31:0] = be_merge(tag_in_reg[31:0],
          avs_writedata, avs_byteenable);
        REG_TAG_HI: tag_in_next[63:32] = be_merge(tag_in_reg[63:32],
          avs_writedata, avs_byteenable);
        REG_DATA_LO: dat_in_next[31:0] = be_merge(dat_in_reg[31:0],
          avs_writedata, avs_byteenable);
        REG_DATA_HI: dat_in_next[63:32] = be_merge(dat_in_reg[63:32],
          avs_writedata, avs_byteenable);
        REG_VA_LOW: vlow_in_next = 9'(be_merge({23'h0, vlow_in_reg},
          avs_writedata, avs_byteenable));
        REG_CMD:
        begin
          cmd_next = 16'(be_merge({16'h0, cmd_reg}, avs_writedata,
            avs_byteenable));
          go_next = 1'b1;
        end
        default: go_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
      cfg_reg <= CFG_RESET;
      tag_in_reg <= 64'h0;
      dat_in_reg <= 64'h0;
      vlow_in_reg <= 9'h000;
      cmd_reg <= 16'h0000;
      go_reg <= 1'b0;
    end
    else
    begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      cfg_reg <= cfg_next;
      tag_in_reg <= tag_in_next;
      dat_in_reg <= dat_in_next;
      vlow_in_reg <= vlow_in_next;
      cmd_reg <= cmd_next;
      go_reg <= go_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
endmodule

// File: mmtt_pkg.sv
package mmtt_pkg;
  // Array geometry
  localparam int FA_N = 16;
  localparam int SA_SETS = 256;
  localparam int N_SA = 3;
  localparam int I_UNIT = 2;
  // Tag word fields
  localparam int TAG_G = 63;
  localparam int TAG_CTX_LSB = 48;
  localparam logic [63:0] TAG_MASK = 64'h9fff_03ff_ffff_ffff;
  // Data word fields
  localparam int D_V = 63;
  localparam int D_SZ_LSB = 61;
  localparam int D_NFO = 60;
  localparam int D_IE = 59;
  localparam int D_L = 6;
  localparam int D_CP = 5;
  localparam int D_CV = 4;
  localparam int D_E = 3;
  localparam int D_P = 2;
  localparam int D_W = 1;
  // Stored data bits per side and buffer kind
  localparam logic [63:0] DMASK_D_FA = 64'hf800_07ff_ffff_e07f;
  localparam logic [63:0] DMASK_D_SA = 64'hf800_07ff_ffff_e03f;
  localparam logic [63:0] DMASK_I_FA = 64'he000_07ff_ffff_e065;
  localparam logic [63:0] DMASK_I_SA = 64'he000_07ff_ffff_e025;
  // Page size codes and low page number compare masks
  localparam logic [1:0] SZ_8K = 2'h0;
  localparam logic [1:0] SZ_64K = 2'h1;
  localparam logic [1:0] SZ_512K = 2'h2;
  localparam logic [1:0] SZ_4M = 2'h3;
  localparam logic [8:0] LM_8K = 9'h1ff;
  localparam logic [8:0] LM_64K = 9'h1f8;
  localparam logic [8:0] LM_512K = 9'h1c0;
  localparam logic [8:0] LM_4M = 9'h000;
  // Fault types
  localparam logic [7:0] FT_NONE = 8'h00;
  localparam logic [7:0] FT_PRIV = 8'h01;
  localparam logic [7:0] FT_SIDE_NF = 8'h02;
  localparam logic [7:0] FT_NFO = 8'h10;
  // Register byte offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_TAG_LO = 8'h04;
  localparam logic [7:0] REG_TAG_HI = 8'h08;
  localparam logic [7:0] REG_DATA_LO = 8'h0c;
  localparam logic [7:0] REG_DATA_HI = 8'h10;
  localparam logic [7:0] REG_VA_LOW = 8'h14;
  localparam logic [7:0] REG_CMD = 8'h18;
  localparam logic [7:0] REG_RTAG_LO = 8'h1c;
  localparam logic [7:0] REG_RTAG_HI = 8'h20;
  localparam logic [7:0] REG_RDATA_LO = 8'h24;
  localparam logic [7:0] REG_RDATA_HI = 8'h28;
  localparam logic [7:0] REG_RVA_LOW = 8'h2c;
  localparam logic [7:0] REG_STATUS = 8'h30;
  // Config and command fields
  localparam int CFG_SZ0_LSB = 0;
  localparam int CFG_SZ1_LSB = 2;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam int CMD_SIDE = 2;
  localparam int CMD_UNIT_LSB = 3;
  localparam int CMD_WAY = 5;
  localparam int CMD_IDX_LSB = 8;
  localparam logic [1:0] OP_FILL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
endpackage

// File: mmtt_assertions.sv
`timescale 1ns/1ns
module mmtt_assertions
  import mmtt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic d_req_valid,
  input wire logic [63:0] d_va,
  input wire logic d_write,
  input wire logic d_nofault,
  input wire logic d_priv,
  input wire logic d_resp_valid,
  input wire logic [42:0] d_pa,
  input wire logic d_miss,
  input wire logic d_exc,
  input wire logic [7:0] d_fault_type,
  input wire logic d_prot,
  input wire logic i_req_valid,
  input wire logic i_resp_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // A data hit answer and a fault answer
  sequence s_dhit;
    d_resp_valid && !d_miss && !d_exc;
  endsequence
  sequence s_dfault(logic [7:0] ft);
    d_exc && d_fault_type == ft;
  endsequence
  // Answers follow requests by exactly one cycle
  chk_d_answer:
    assert property (d_req_valid |=> d_resp_valid)
    else $error("data answer missing");
  chk_i_answer:
    assert property (i_req_valid |=> i_resp_valid)
    else $error("instr answer missing");
  chk_no_spur:
    assert property (!d_req_valid |=> !d_resp_valid)
    else $error("data answer without request");
  // Page offset passes through untouched
  chk_d_offset:
    assert property (s_dhit |-> d_pa[12:0] == $past(d_va[12:0]))
    else $error("page offset changed");
  // Traps exclude each other; privileged and no-fault-only fault types match the access
  chk_miss_clean:
    assert property (d_miss |-> d_resp_valid && !d_exc && !d_prot)
    else $error("miss with other trap");
  chk_prot_store:
    assert property (d_prot |-> $past(d_write) && !d_exc && !d_miss)
    else $error("protection trap without store");
  chk_nfo_type:
    assert property (s_dfault(FT_NFO) |-> !$past(d_nofault))
    else $error("no-fault load trapped");
  chk_priv_type:
    assert property (s_dfault(FT_PRIV) |-> !$past(d_priv))
    else $error("supervisor access trapped");
endmodule
bind mmtt_top mmtt_assertions i_chk (
  .clk, .reset_n, .d_req_valid, .d_va, .d_write, .d_nofault, .d_priv,
  .d_resp_valid, .d_pa, .d_miss, .d_exc, .d_fault_type, .d_prot,
  .i_req_valid, .i_resp_valid
);

// File: mmtt_pipe_model.sv
`timescale 1ns/1ns
module mmtt_pipe_model (
  input wire logic clk,
  output logic d_req_valid,
  output logic [63:0] d_va,
  output logic [12:0] d_ctx,
  output logic d_write,
  output logic d_nofault,
  output logic d_priv,
  output logic d_little,
  output logic i_req_valid,
  output logic [63:0] i_va,
  output logic [12:0] i_ctx,
  output logic i_priv
);
  // Idle pipelines at time zero
  initial
  begin
    {d_req_valid, d_write, d_nofault, d_priv, d_little} = 5'h0;
    {i_req_valid, i_priv, d_ctx, i_ctx} = 28'h0;
    {d_va, i_va} = 128'h0;
  end
  // One lookup per chosen side; address scrambled once released
  task automatic look(input logic dq, input logic iq,
    input logic [63:0] va, input logic [12:0] cx, input logic [3:0] f);
    begin
      @(posedge clk);
      d_req_valid <= dq;
      i_req_valid <= iq;
      d_va <= va;
      i_va <= va;
      d_ctx <= cx;
      i_ctx <= cx;
      {d_write, d_nofault, d_priv, d_little} <= f;
      i_priv <= f[1];
      @(posedge clk);
      d_req_valid <= 1'b0;
      i_req_valid <= 1'b0;
      d_va <= ~va;
      i_va <= ~va;
      #1;
    end
  endtask
endmodule

// File: mmtt_tb_top.sv
`timescale 1ns/1ns
module mmtt_tb_top;
  import mmtt_pkg::*;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_val;
  logic [3:0] avs_byteenable;
  logic d_req_valid, d_write, d_nofault, d_priv, d_little, d_resp_valid;
  logic d_miss, d_exc, d_prot, d_little_out, d_cacheable, d_l1_cacheable;
  logic d_side_effect, i_req_valid, i_priv, i_resp_valid, i_miss, i_exc;
  logic i_cacheable;
  logic [63:0] d_va, i_va, v;
  logic [12:0] d_ctx, i_ctx;
  logic [42:0] d_pa, i_pa;
  logic [7:0] d_fault_type;
  int failures, samples_checked;
  localparam logic [63:0] VA_A = 64'h0000_0abc_d000_0000;
  localparam logic [63:0] VA_T = VA_A + 64'h2a_beef;
  localparam logic [63:0] VA_B = 64'h0000_0000_1357_6123;
  localparam logic [63:0] TAG_A = {3'h0, 13'h5, 6'h0, VA_A[63:22]};
  localparam logic [63:0] TAG_B = {1'b1, 15'h0, 6'h0, VA_B[63:22]};
  localparam logic [63:0] DAT_A = 64'he800_0024_68bf_e030;
  localparam logic [63:0] DAT_C = 64'h8000_0000_0eee_e020;
  localparam logic [63:0] DAT_B = {5'h12, 9'h1ff, 7'h0, 30'h0abc,
    6'h3f, 7'h57};

  mmtt_top i_dut (
    .clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .d_req_valid,
    .d_va, .d_ctx, .d_write, .d_nofault, .d_priv, .d_little,
    .d_resp_valid, .d_pa, .d_miss, .d_exc, .d_fault_type, .d_prot,
    .d_little_out, .d_cacheable, .d_l1_cacheable, .d_side_effect,
    .i_req_valid, .i_va, .i_ctx, .i_priv, .i_resp_valid, .i_pa,
    .i_miss, .i_exc, .i_cacheable
  );
  mmtt_pipe_model i_pipe (
    .clk, .d_req_valid, .d_va, .d_ctx, .d_write, .d_nofault, .d_priv,
    .d_little, .i_req_valid, .i_va, .i_ctx, .i_priv
  );

  // Free running clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        failures++;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task automatic finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge clk);
      rd_val = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask

  task automatic w64(input logic [7:0] a, input logic [63:0] d);
    begin
      bus(1'b1, a, d[31:0]);
      bus(1'b1, a + 8'h4, d[63:32]);
    end
  endtask

  task automatic r64(input logic [7:0] a);
    begin
      bus(1'b0, a, 32'h0);
      v[31:0] = rd_val;
      bus(1'b0, a + 8'h4, 32'h0);
      v[63:32] = rd_val;
    end
  endtask

  // Load one entry; lookups see it two edges later
  task automatic fill(input logic [63:0] t, input logic [63:0] dt,
    input logic [8:0] vl, input logic [31:0] cmd);
    begin
      w64(REG_TAG_LO, t);
      w64(REG_DATA_LO, dt);
      bus(1'b1, REG_VA_LOW, {23'h0, vl});
      bus(1'b1, REG_CMD, cmd);
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic t_regs;
    begin
      bus(1'b0, REG_CONFIG, 32'h0);
      chk(rd_val, {28'h0, CFG_RESET});
      bus(1'b1, 8'hfc, 32'hffff_ffff);
      bus(1'b0, 8'hfc, 32'h0);
      chk(rd_val, 32'h0);
      i_pipe.look(1'b1, 1'b1, VA_T, 13'h5, 4'h2);
      chk(d_miss, 1'b1);
      chk(i_miss, 1'b1);
      $display("test regs done");
    end
  endtask

  task automatic t_hit;
    begin
      fill(TAG_A, DAT_A, 9'h0, 32'h0);
      fill(TAG_A, DAT_C, VA_T[21:13], 32'h4);
      fill(TAG_B, DAT_B, VA_B[21:13], 32'h0);
      i_pipe.look(1'b1, 1'b1, VA_T, 13'h5, 4'h3);
      chk(d_pa, {DAT_A[42:22], VA_T[21:0]});
      chk(d_little_out, 1'b0);
      chk(d_l1_cacheable, 1'b1);
      chk({d_exc, d_side_effect, i_exc}, 3'h0);
      chk(i_pa, {DAT_C[42:13], VA_T[12:0]});
      chk(i_cacheable, 1'b1);
      i_pipe.look(1'b1, 1'b0, VA_T, 13'h5, 4'ha);
      chk(d_prot, 1'b1);
      i_pipe.look(1'b1, 1'b1, VA_T, 13'h6, 4'h2);
      chk(d_miss, 1'b1);
      chk(i_miss, 1'b1);
      $display("test hit done");
    end
  endtask

  task automatic t_fault;
    begin
      i_pipe.look(1'b1, 1'b0, VA_B, 13'h7, 4'h0);
      chk(d_fault_type, FT_PRIV);
      i_pipe.look(1'b1, 1'b0, VA_B, 13'h7, 4'h2);
      chk(d_fault_type, FT_NFO);
      i_pipe.look(1'b1, 1'b0, VA_B, 13'h7, 4'h6);
      chk(d_exc, 1'b0);
      chk(d_pa, {DAT_B[42:13], VA_B[12:0]});
      chk(d_cacheable, 1'b0);
      $display("test fault done");
    end
  endtask

  task automatic t_back;
    begin
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rd_val[13:0], {6'h20, VA_B[20:13]});
      bus(1'b1, REG_CMD, {16'h0, rd_val[7:0], 2'h0, rd_val[8],
        2'h1, rd_val[11], OP_READ});
      r64(REG_RTAG_LO);
      chk(v, TAG_B & TAG_MASK);
      r64(REG_RDATA_LO);
      chk(v, DAT_B & DMASK_D_SA);
      bus(1'b0, REG_RVA_LOW, 32'h0);
      chk(rd_val, {23'h0, VA_B[21:13]});
      $display("test back done");
    end
  endtask

  // Main sequence
  initial
  begin
    {reset_n, avs_read, avs_write, avs_address} = 11'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    failures = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    chk({avs_waitrequest, d_resp_valid}, 2'h2);
    reset_n <= 1'b1;
    t_regs;
    t_hit;
    t_fault;
    t_back;
    finish_test;
  end

  // Watchdog
  initial
  begin
    #1000000;
    failures++;
    finish_test;
  end
endmodule
